//--- pkg/ptab_map.vh
`ifndef PTAB_MAP_VH
`define PTAB_MAP_VH

// Register indices; byte address is four times the index
`define PTAB_IDX_TA_IRQ 10'h001
`define PTAB_IDX_TB_IRQ 10'h002
`define PTAB_IDX_TA_MODE 10'h008
`define PTAB_IDX_TB_MODE_ONE 10'h009
`define PTAB_IDX_TB_LOW 10'h00a
`define PTAB_IDX_TB_HIGH 10'h00b
`define PTAB_IDX_CAP_FLAGS 10'h021
`define PTAB_IDX_EVENT_PIN 10'h024
`define PTAB_IDX_TB_MODE_TWO 10'h026
`define PTAB_IDX_SW_CLEAR 10'h030

// Field positions
`define PTAB_TA_IRQ_BIT 2
`define PTAB_TB_IRQ_BIT 0
`define PTAB_TIME_BASE_BIT 3
`define PTAB_RELOAD_BIT 3
`define PTAB_CAP_STATUS_BIT 0
`define PTAB_CAP_ERROR_BIT 1
`define PTAB_CAPTURE_EN_BIT 2
`define PTAB_EVENT_FN_BIT 0
`define PTAB_CLR_W_BIT 0
`define PTAB_CLR_TA_BIT 1

// Codes and reset values
`define PTAB_SRC_EVENT 3'h7
`define PTAB_EDGE_FALL 2'h1
`define PTAB_EDGE_RISE 2'h2
`define PTAB_EDGE_BOTH 2'h3
`define PTAB_MODE4_RESET 4'h0
`define PTAB_MODE3_RESET 3'h0
`define PTAB_S_RESET 11'h000
`define PTAB_W_RESET 5'h00
`define PTAB_CNT_RESET 8'h00
`define PTAB_CNT_MAX 8'hff

// Prescaler tap tables, one 4-bit divider exponent per code
`define PTAB_TB_TAPS 32'h0123579b
`define PTAB_TA_S_TAPS 32'h0123579b
`define PTAB_TA_W_TAPS 32'h54321054

// Timing counts: settle in cycles of pclk, divider terminal count in crystal rising edges
`define PTAB_MODE_ONE_SETTLE 2
`define PTAB_XTAL_DIV 3'h7

`endif

//--- rtl/ptab_xtal_presc.v
`timescale 1ns/1ns
`default_nettype none
`include "ptab_map.vh"

// Crystal clock divided by eight, then a five-bit prescaler
module ptab_xtal_presc (
  input wire pclk,
  input wire presetn,
  input wire crystal_clock_input,
  input wire sw_clear,
  output wire [4:0] w_cnt,
  output wire w_step
);
  reg xtal_prev_q;
  reg [2:0] div_q;
  reg [4:0] w_q;
  wire rise;

  assign rise = crystal_clock_input & ~xtal_prev_q;
  assign w_step = rise & (div_q == `PTAB_XTAL_DIV);
  assign w_cnt = w_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_prev_q <= 1'b0;
      div_q <= 3'h0;
      w_q <= `PTAB_W_RESET;
    end else begin
      xtal_prev_q <= crystal_clock_input;
      if (rise) begin
        div_q <= div_q + 3'h1;
      end
      if (sw_clear) begin
        w_q <= `PTAB_W_RESET;
      end else if (w_step) begin
        w_q <= w_q + 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/ptab_edge_det.v
`timescale 1ns/1ns
`default_nettype none
`include "ptab_map.vh"

// Selected-edge detector on the event pin
module ptab_edge_det (
  input wire pclk,
  input wire presetn,
  input wire pin,
  input wire enable,
  input wire [1:0] edge_sel,
  output wire edge_hit
);
  reg prev_q;
  wire rise;
  wire fall;

  assign rise = pin & ~prev_q;
  assign fall = ~pin & prev_q;
  assign edge_hit = enable &
    ((rise & edge_sel[1]) | (fall & edge_sel[0]));

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= pin;
    end
  end
endmodule
`default_nettype wire

//--- rtl/ptab_top.v
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ptab_map.vh"

module ptab_top #(
  parameter [31:0] TB_TAPS = `PTAB_TB_TAPS,
  parameter [31:0] TA_S_TAPS = `PTAB_TA_S_TAPS,
  parameter [31:0] TA_W_TAPS = `PTAB_TA_W_TAPS,
  parameter integer MODE_ONE_SETTLE = `PTAB_MODE_ONE_SETTLE
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire low_power_halt,
  input wire crystal_clock_input,
  input wire event_trigger_pin,
  output reg event_pin_is_event,
  output reg timer_a_irq_flag,
  output reg timer_b_irq_flag,
  output reg capture_status_flag,
  output reg capture_error_flag
);
  function tap_hit;
    input [10:0] cnt;
    input [3:0] n;
    reg [10:0] m;
    begin
      m = (11'h001 << n) - 11'h001;
      tap_hit = ((cnt & m) == m);
    end
  endfunction

  function [3:0] tap_of;
    input [31:0] table_v;
    input [2:0] code;
    begin
      tap_of = table_v[{code, 2'b00} +: 4];
    end
  endfunction

  // Register state
  reg [10:0] s_q;
  reg [3:0] timer_a_mode_q;
  reg [7:0] timer_a_q;
  reg [3:0] mode_one_pend_q;
  reg [3:0] timer_b_mode_one_q;
  reg [1:0] settle_q;
  reg mode_one_busy_q;
  reg [2:0] timer_b_mode_two_q;
  reg [3:0] load_low_q;
  reg [3:0] load_high_q;
  reg [7:0] timer_b_q;
  reg [7:0] read_q;

  // Bus decode
  wire [9:0] idx;
  wire setup;
  wire access;
  wire wr;
  wire rd;
  reg hit;
  reg [3:0] rd_nib;

  assign idx = paddr[11:2];
  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign wr = access & pwrite & ~pslverr;
  // Read strobe in the setup cycle, when the upper digit is sampled
  assign rd = setup & ~pwrite;

  wire wr_ta_irq;
  wire wr_tb_irq;
  wire wr_ta_mode;
  wire wr_mode_one;
  wire wr_low;
  wire wr_high;
  wire wr_cap;
  wire wr_evpin;
  wire wr_mode_two;
  wire wr_clr;
  wire rd_high;
  assign wr_ta_irq = wr & (idx == `PTAB_IDX_TA_IRQ);
  assign wr_tb_irq = wr & (idx == `PTAB_IDX_TB_IRQ);
  assign wr_ta_mode = wr & (idx == `PTAB_IDX_TA_MODE);
  assign wr_mode_one = wr & (idx == `PTAB_IDX_TB_MODE_ONE);
  assign wr_low = wr & (idx == `PTAB_IDX_TB_LOW);
  assign wr_high = wr & (idx == `PTAB_IDX_TB_HIGH);
  assign wr_cap = wr & (idx == `PTAB_IDX_CAP_FLAGS);
  assign wr_evpin = wr & (idx == `PTAB_IDX_EVENT_PIN);
  assign wr_mode_two = wr & (idx == `PTAB_IDX_TB_MODE_TWO);
  assign wr_clr = wr & (idx == `PTAB_IDX_SW_CLEAR);
  assign rd_high = rd & (idx == `PTAB_IDX_TB_HIGH);

  // Mode fields
  wire time_base_select;
  wire tb_reload;
  wire [2:0] tb_src;
  wire tb_capture;
  wire [1:0] tb_edge;
  assign time_base_select = timer_a_mode_q[`PTAB_TIME_BASE_BIT];
  assign tb_reload = timer_b_mode_one_q[`PTAB_RELOAD_BIT];
  assign tb_src = timer_b_mode_one_q[2:0];
  assign tb_capture = timer_b_mode_two_q[`PTAB_CAPTURE_EN_BIT];
  assign tb_edge = timer_b_mode_two_q[1:0];

  // Software clears
  wire clr_w;
  wire clr_ta;
  assign clr_w = wr_clr & pwdata[`PTAB_CLR_W_BIT];
  assign clr_ta = wr_clr & pwdata[`PTAB_CLR_TA_BIT] & time_base_select;

  // Prescaler W
  wire [4:0] w_cnt;
  wire w_step;

  ptab_xtal_presc u_xtal (
    .pclk(pclk),
    .presetn(presetn),
    .crystal_clock_input(crystal_clock_input),
    .sw_clear(clr_w),
    .w_cnt(w_cnt),
    .w_step(w_step)
  );

  // Event edge detection
  wire ev_edge;

  ptab_edge_det u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin(event_trigger_pin),
    .enable(event_pin_is_event),
    .edge_sel(tb_edge),
    .edge_hit(ev_edge)
  );

  // Prescaler S
  wire s_run;
  assign s_run = ~low_power_halt;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= `PTAB_S_RESET;
    end else if (s_run) begin
      s_q <= s_q + 11'h001;
    end
  end

  // Timer A clock selection
  wire ta_tick_s;
  wire ta_tick_w;
  wire ta_tick;
  wire ta_ovf;
  assign ta_tick_s = s_run & tap_hit(s_q, tap_of(TA_S_TAPS, timer_a_mode_q[2:0]));
  assign ta_tick_w = w_step & tap_hit({6'h00, w_cnt}, tap_of(TA_W_TAPS, timer_a_mode_q[2:0]));
  assign ta_tick = time_base_select ? ta_tick_w : ta_tick_s;
  assign ta_ovf = ta_tick & (timer_a_q == `PTAB_CNT_MAX);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_a_mode_q <= `PTAB_MODE4_RESET;
      timer_a_q <= `PTAB_CNT_RESET;
    end else begin
      if (wr_ta_mode) begin
        timer_a_mode_q <= pwdata[3:0];
      end
      if (clr_ta) begin
        timer_a_q <= `PTAB_CNT_RESET;
      end else if (ta_tick) begin
        timer_a_q <= timer_a_q + 8'h01;
      end
    end
  end

  // Timer B mode one with delayed effect
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_one_pend_q <= `PTAB_MODE4_RESET;
      timer_b_mode_one_q <= `PTAB_MODE4_RESET;
      settle_q <= 2'h0;
      mode_one_busy_q <= 1'b0;
    end else if (wr_mode_one) begin
      mode_one_pend_q <= pwdata[3:0];
      settle_q <= MODE_ONE_SETTLE[1:0] - 2'h1;
      mode_one_busy_q <= 1'b1;
    end else if (mode_one_busy_q) begin
      if (settle_q == 2'h1 || settle_q == 2'h0) begin
        timer_b_mode_one_q <= mode_one_pend_q;
        mode_one_busy_q <= 1'b0;
        settle_q <= 2'h0;
      end else begin
        settle_q <= settle_q - 2'h1;
      end
    end
  end

  // Timer B clocking
  wire tb_src_event;
  wire tb_tick_s;
  wire tb_trig;
  wire tb_tick;
  wire tb_ovf;
  assign tb_src_event = (tb_src == `PTAB_SRC_EVENT);
  assign tb_tick_s = s_run & tap_hit(s_q, tap_of(TB_TAPS, tb_src));
  assign tb_trig = tb_capture & ev_edge;
  assign tb_tick = tb_src_event ? (~tb_capture & ev_edge) : tb_tick_s;
  assign tb_ovf = tb_tick & (timer_b_q == `PTAB_CNT_MAX);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_b_mode_two_q <= `PTAB_MODE3_RESET;
      event_pin_is_event <= 1'b0;
      load_low_q <= 4'h0;
      load_high_q <= 4'h0;
      timer_b_q <= `PTAB_CNT_RESET;
      read_q <= `PTAB_CNT_RESET;
    end else begin
      if (wr_mode_two) begin
        timer_b_mode_two_q <= pwdata[2:0];
      end
      if (wr_evpin) begin
        event_pin_is_event <= pwdata[`PTAB_EVENT_FN_BIT];
      end
      if (wr_low) begin
        load_low_q <= pwdata[3:0];
      end
      if (wr_high) begin
        load_high_q <= pwdata[3:0];
        timer_b_q <= {pwdata[3:0], load_low_q};
      end else if (tb_trig) begin
        timer_b_q <= `PTAB_CNT_RESET;
      end else if (tb_ovf) begin
        timer_b_q <= tb_reload ? {load_high_q, load_low_q} : `PTAB_CNT_RESET;
      end else if (tb_tick) begin
        timer_b_q <= timer_b_q + 8'h01;
      end
      if (tb_trig) begin
        read_q <= timer_b_q;
      end else if (rd_high & ~tb_capture) begin
        read_q <= timer_b_q;
      end
    end
  end

  // Sticky flags; a set in the clearing cycle wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_a_irq_flag <= 1'b0;
      timer_b_irq_flag <= 1'b0;
      capture_status_flag <= 1'b0;
      capture_error_flag <= 1'b0;
    end else begin
      if (ta_ovf) begin
        timer_a_irq_flag <= 1'b1;
      end else if (wr_ta_irq & ~pwdata[`PTAB_TA_IRQ_BIT]) begin
        timer_a_irq_flag <= 1'b0;
      end
      if (tb_ovf | tb_trig) begin
        timer_b_irq_flag <= 1'b1;
      end else if (wr_tb_irq & ~pwdata[`PTAB_TB_IRQ_BIT]) begin
        timer_b_irq_flag <= 1'b0;
      end
      if (tb_trig) begin
        capture_status_flag <= 1'b1;
      end else if (wr_cap & ~pwdata[`PTAB_CAP_STATUS_BIT]) begin
        capture_status_flag <= 1'b0;
      end
      if (capture_status_flag & (tb_trig | (tb_capture & tb_ovf))) begin
        capture_error_flag <= 1'b1;
      end else if (wr_cap & ~pwdata[`PTAB_CAP_ERROR_BIT]) begin
        capture_error_flag <= 1'b0;
      end
    end
  end

  // Read mux and address check, evaluated in the setup cycle
  always @* begin
    hit = 1'b1;
    rd_nib = 4'h0;
    case (idx)
      `PTAB_IDX_TA_IRQ: rd_nib = {1'b0, timer_a_irq_flag, 2'b00};
      `PTAB_IDX_TB_IRQ: rd_nib = {3'b000, timer_b_irq_flag};
      `PTAB_IDX_CAP_FLAGS: rd_nib = {2'b00, capture_error_flag, capture_status_flag};
      `PTAB_IDX_TB_LOW: rd_nib = read_q[3:0];
      `PTAB_IDX_TB_HIGH: rd_nib = tb_capture ? read_q[7:4] : timer_b_q[7:4];
      `PTAB_IDX_TA_MODE,
      `PTAB_IDX_TB_MODE_ONE,
      `PTAB_IDX_EVENT_PIN,
      `PTAB_IDX_TB_MODE_TWO,
      `PTAB_IDX_SW_CLEAR: rd_nib = 4'h0;
      default: hit = 1'b0;
    endcase
  end

  // APB answer: one access cycle, no wait states
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= ~hit;
        prdata <= (pwrite | ~hit) ? 32'h00000000 : {28'h0000000, rd_nib};
      end else if (!psel) begin
        pslverr <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/ptab_properties.sv
`timescale 1ns/1ns
`default_nettype none
`include "ptab_map.vh"
module ptab_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic event_pin_is_event,
  input wire logic timer_a_irq_flag,
  input wire logic timer_b_irq_flag,
  input wire logic capture_status_flag,
  input wire logic capture_error_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic [9:0] idx = paddr[11:2];
  wire logic wr = psel && penable && pready && pwrite;
  wire logic clr_ta = wr && idx == `PTAB_IDX_TA_IRQ;
  wire logic clr_tb = wr && idx == `PTAB_IDX_TB_IRQ;
  wire logic clr_cf = wr && idx == `PTAB_IDX_CAP_FLAGS;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_rd(logic [9:0] i);
    s_setup ##1 (pready && !pwrite && idx == i);
  endsequence
  sequence s_wr(logic [9:0] i);
    wr && idx == i;
  endsequence
  property p_ta_mode_wo;
    s_rd(`PTAB_IDX_TA_MODE) |-> prdata == 32'h0;
  endproperty
  a_ta_mode_wo: assert property (p_ta_mode_wo) else $error("mode A read");
  property p_mode_one_wo;
    s_rd(`PTAB_IDX_TB_MODE_ONE) |-> prdata == 32'h0;
  endproperty
  a_mode_one_wo: assert property (p_mode_one_wo) else $error("mode B read");
  property p_ta_sticky;
    timer_a_irq_flag && !clr_ta |=> timer_a_irq_flag;
  endproperty
  a_ta_sticky: assert property (p_ta_sticky) else $error("flag A lost");
  property p_tb_sticky;
    timer_b_irq_flag && !clr_tb |=> timer_b_irq_flag;
  endproperty
  a_tb_sticky: assert property (p_tb_sticky) else $error("flag B lost");
  property p_cs_sticky;
    capture_status_flag && !clr_cf |=> capture_status_flag;
  endproperty
  a_cs_sticky: assert property (p_cs_sticky) else $error("status lost");
  property p_ce_sticky;
    capture_error_flag && !clr_cf |=> capture_error_flag;
  endproperty
  a_ce_sticky: assert property (p_ce_sticky) else $error("error lost");
  property p_err_cause;
    $rose(capture_error_flag) |-> $past(capture_status_flag);
  endproperty
  a_err_cause: assert property (p_err_cause) else $error("error no status");
  property p_cap_irq;
    $rose(capture_status_flag) |-> timer_b_irq_flag;
  endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("capture no flag");
  property p_evsel;
    s_wr(`PTAB_IDX_EVENT_PIN) |=> event_pin_is_event == $past(pwdata[0]);
  endproperty
  a_evsel: assert property (p_evsel) else $error("pin select");
endmodule
bind ptab_top ptab_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .event_pin_is_event(event_pin_is_event),
  .timer_a_irq_flag(timer_a_irq_flag), .timer_b_irq_flag(timer_b_irq_flag),
  .capture_status_flag(capture_status_flag), .capture_error_flag(capture_error_flag));
`default_nettype wire

//--- verif/ptab_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module ptab_pin_model (
  input wire logic pclk,
  output logic event_trigger_pin,
  output logic crystal_clock_input
);
  initial begin
    event_trigger_pin = 1'b1;
    crystal_clock_input = 1'b0;
  end
  always @(posedge pclk) begin
    crystal_clock_input <= ~crystal_clock_input;
  end
  // Low then high, each two cycles
  task pulse(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (2) @(posedge pclk);
      event_trigger_pin <= 1'b0;
      repeat (2) @(posedge pclk);
      event_trigger_pin <= 1'b1;
    end
  endtask
endmodule
`default_nettype wire

//--- verif/prescaled_timer_a_b_unit_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "ptab_map.vh"
module prescaled_timer_a_b_unit_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic low_power_halt = 1'b0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, ev_sel, ta_irq, tb_irq, cap_st, cap_err, xtal, evpin;
  logic [31:0] rdv;
  logic erv;
  logic [1:0] codes [3] = '{`PTAB_EDGE_FALL, `PTAB_EDGE_BOTH, `PTAB_EDGE_RISE};
  int npul [3] = '{3, 2, 1};
  logic [7:0] cnts [3] = '{8'h03, 8'h07, 8'h08};
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #25 pclk = ~pclk;
  ptab_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .low_power_halt(low_power_halt), .crystal_clock_input(xtal),
    .event_trigger_pin(evpin), .event_pin_is_event(ev_sel), .timer_a_irq_flag(ta_irq),
    .timer_b_irq_flag(tb_irq), .capture_status_flag(cap_st), .capture_error_flag(cap_err));
  ptab_pin_model pin (.pclk(pclk), .event_trigger_pin(evpin), .crystal_clock_input(xtal));
  task results;
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [9:0] i, input logic [3:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {28'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd_cnt(input logic [7:0] exp);
    logic [3:0] h;
    apb(1'b0, `PTAB_IDX_TB_HIGH, 4'h0);
    h = rdv[3:0];
    apb(1'b0, `PTAB_IDX_TB_LOW, 4'h0);
    chk({h, rdv[3:0]}, exp);
  endtask
  task load(input logic [7:0] v);
    apb(1'b1, `PTAB_IDX_TB_LOW, v[3:0]);
    apb(1'b1, `PTAB_IDX_TB_HIGH, v[7:4]);
  endtask
  task mode_one(input logic [3:0] v);
    apb(1'b1, `PTAB_IDX_TB_MODE_ONE, v);
    repeat (`PTAB_MODE_ONE_SETTLE) @(posedge pclk);
  endtask
  task wait_tb;
    for (int i = 0; i < 40 && tb_irq !== 1'b1; i++) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({3'h0, ev_sel, ta_irq, tb_irq, cap_st, cap_err}, 8'h00);
    apb(1'b0, `PTAB_IDX_TA_MODE, 4'h0);
    chk({erv, rdv[6:0]}, 8'h00);
    apb(1'b0, 10'h3ff, 4'h0);
    chk({erv, rdv[6:0]}, 8'h80);
    mode_one(4'h7);
    load(8'h5a);
    rd_cnt(8'h5a);
    apb(1'b1, `PTAB_IDX_TB_LOW, 4'h3);
    rd_cnt(8'h5a);
    apb(1'b1, `PTAB_IDX_EVENT_PIN, 4'h1);
    chk({7'h0, ev_sel}, 8'h01);
    load(8'h00);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, `PTAB_IDX_TB_MODE_TWO, {2'b00, codes[k]});
      pin.pulse(npul[k]);
      repeat (4) @(posedge pclk);
      rd_cnt(cnts[k]);
    end
    mode_one(4'he);
    load(8'hfe);
    wait_tb();
    chk({7'h0, tb_irq}, 8'h01);
    apb(1'b1, `PTAB_IDX_TB_IRQ, 4'h0);
    wait_tb();
    chk({7'h0, tb_irq}, 8'h01);
    mode_one(4'h6);
    load(8'hfe);
    repeat (10) @(posedge pclk);
    apb(1'b1, `PTAB_IDX_TB_IRQ, 4'h0);
    chk({7'h0, tb_irq}, 8'h00);
    repeat (40) @(posedge pclk);
    chk({7'h0, tb_irq}, 8'h00);
    low_power_halt <= 1'b1;
    load(8'h42);
    apb(1'b1, `PTAB_IDX_TB_MODE_TWO, 4'h5);
    pin.pulse(1);
    repeat (4) @(posedge pclk);
    chk({5'h0, cap_st, cap_err, tb_irq}, 8'h05);
    rd_cnt(8'h42);
    pin.pulse(1);
    repeat (4) @(posedge pclk);
    chk({6'h0, cap_st, cap_err}, 8'h03);
    rd_cnt(8'h00);
    apb(1'b1, `PTAB_IDX_CAP_FLAGS, 4'h0);
    chk({6'h0, cap_st, cap_err}, 8'h00);
    low_power_halt <= 1'b0;
    apb(1'b1, `PTAB_IDX_TA_MODE, 4'ha);
    apb(1'b1, `PTAB_IDX_SW_CLEAR, 4'h3);
    repeat (4000) @(posedge pclk);
    chk({7'h0, ta_irq}, 8'h00);
    for (int i = 0; i < 200 && ta_irq !== 1'b1; i++) @(posedge pclk);
    chk({7'h0, ta_irq}, 8'h01);
    apb(1'b1, `PTAB_IDX_TA_IRQ, 4'h0);
    chk({7'h0, ta_irq}, 8'h00);
    results();
  end
endmodule
`default_nettype wire
